// ---- rtl/pcg_clock_gen.sv ----
// pdm clock generator: dividers, gates, bit clock, sampling, apb
//
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
module pcg_clock_gen (
  // apb clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // microphone pins
  input wire logic mic_data,
  output logic mic_bit_clock,
  // converter core clocks
  output logic core_clk_left,
  output logic core_clk_right,
  output logic core_tick_left,
  output logic core_tick_right,
  // sampled bits and frame strobe
  output logic left_bit,
  output logic left_valid,
  output logic right_bit,
  output logic right_valid,
  output logic frame_strobe,
  output logic [6:0] decimation_setting,
  // clock source control
  output logic [1:0] module_clock_select,
  output logic force_secondary_rc_on,
  output logic secondary_rc_request,
  output logic crystal32k_enable
);
  import pcg_pkg::*;

  typedef struct packed {
    logic en;
    logic [1:0] chset;
    logic swap;
    logic [1:0] csel;
    logic force_on;
    logic [1:0] cdiv;
    logic [3:0] bdiv;
    logic [2:0] dly;
    logic [6:0] dec;
    logic seq_err;
    logic a_en;
    logic [1:0] a_chset;
    logic a_swap;
    logic [3:0] a_bdiv;
    logic [2:0] a_dly;
    logic [6:0] a_dec;
    logic [1:0] dsync;
    logic [6:0] dpipe;
    logic bclk;
    logic bprev;
    logic lbit;
    logic lval;
    logic rbit;
    logic rval;
    logic frame;
    logic [7:0] fcnt;
    logic rc_req;
    logic x32;
  } pcg_state_t;

  pcg_state_t s_reg, s_next;
  logic core_lvl, core_tick;
  logic left_gate_enable, stereo_gate_enable;
  logic bit_lvl;
  logic wr, rd_ok, dec_illegal;
  logic [7:0] dline;
  logic rise, fall, to_left;

  // ****************************************
  // clock tree
  // ****************************************

  // converter clock straight off the master clock
  pcg_div #(.W(2)) u_core_div (
    .pclk(pclk),
    .presetn(presetn),
    .step(1'b1),
    .div_val(s_reg.cdiv),
    .clk_lvl(core_lvl),
    .clk_tick(core_tick)
  );

  // left gate enable follows the enable alone; the stereo gate also follows the active channel set
  assign left_gate_enable = s_reg.a_en;
  assign stereo_gate_enable = s_reg.a_en & s_reg.a_chset[PCG_STEREO_BIT];

  pcg_gate u_gate_l (
    .pclk(pclk),
    .presetn(presetn),
    .src_lvl(core_lvl),
    .src_tick(core_tick),
    .en(left_gate_enable),
    .g_lvl(core_clk_left),
    .g_tick(core_tick_left)
  );

  pcg_gate u_gate_r (
    .pclk(pclk),
    .presetn(presetn),
    .src_lvl(core_lvl),
    .src_tick(core_tick),
    .en(stereo_gate_enable),
    .g_lvl(core_clk_right),
    .g_tick(core_tick_right)
  );

  // bit clock counts left converter clock periods
  pcg_div #(.W(4)) u_bit_div (
    .pclk(pclk),
    .presetn(presetn),
    .step(core_tick_left),
    .div_val(s_reg.a_bdiv),
    .clk_lvl(bit_lvl),
    .clk_tick()
  );

  // ****************************************
  // register access and next state
  // ****************************************

  assign wr = psel & penable & pwrite;
  assign rd_ok = (paddr == PCG_CTRL_OFS) | (paddr == PCG_DIV_OFS) | (paddr == PCG_STAT_OFS);
  assign dec_illegal = !((s_reg.dec >= PCG_DEC_MIN && s_reg.dec <= PCG_DEC_MAX)
                         || s_reg.dec == PCG_DEC_ALT);
  assign dline = {s_reg.dpipe, bit_lvl};
  assign rise = s_reg.bclk & !s_reg.bprev;
  assign fall = !s_reg.bclk & s_reg.bprev;
  assign to_left = rise ? !s_reg.a_swap : s_reg.a_swap;

  always_comb begin
    s_next = s_reg;
    s_next.lval = 1'b0;
    s_next.rval = 1'b0;
    s_next.frame = 1'b0;
    // software writes
    if (wr && paddr == PCG_CTRL_OFS) begin
      s_next.en = pwdata[PCG_EN_POS];
      s_next.chset = pwdata[PCG_CHSET_POS +: 2];
      s_next.swap = pwdata[PCG_SWAP_POS];
      s_next.csel = pwdata[PCG_CSEL_POS +: 2];
      s_next.force_on = pwdata[PCG_FORCE_POS];
    end
    if (wr && paddr == PCG_DIV_OFS) begin
      s_next.cdiv = pwdata[PCG_CDIV_POS +: 2];
      s_next.bdiv = pwdata[PCG_BDIV_POS +: 4];
      s_next.dly = pwdata[PCG_DLY_POS +: 3];
      s_next.dec = pwdata[PCG_DEC_POS +: 7];
    end
    // source change without the force held flags a sequence error; set wins
    if (wr && paddr == PCG_STAT_OFS && pwdata[PCG_SEQ_POS]) begin
      s_next.seq_err = 1'b0;
    end
    if (wr && paddr == PCG_CTRL_OFS && pwdata[PCG_CSEL_POS +: 2] != s_reg.csel
        && !s_reg.force_on) begin
      s_next.seq_err = 1'b1;
    end
    // settings reach the converter side only at its clock edge
    if (core_tick) begin
      s_next.a_en = s_reg.en;
      s_next.a_chset = s_reg.chset;
      s_next.a_swap = s_reg.swap;
      s_next.a_bdiv = s_reg.bdiv;
      s_next.a_dly = s_reg.dly;
      s_next.a_dec = s_reg.dec;
    end
    // pin synchroniser and phase delay line
    s_next.dsync = {s_reg.dsync[0], mic_data};
    s_next.dpipe = dline[6:0];
    s_next.bclk = dline[s_reg.a_dly];
    s_next.bprev = s_reg.bclk;
    // edge to channel mapping; mono never drives the right side
    if (rise || fall) begin
      if (to_left) begin
        s_next.lbit = s_reg.dsync[1];
        s_next.lval = 1'b1;
      end else if (s_reg.a_chset[PCG_STEREO_BIT]) begin
        s_next.rbit = s_reg.dsync[1];
        s_next.rval = 1'b1;
      end
    end
    if (!s_reg.a_chset[PCG_STEREO_BIT]) begin
      s_next.rbit = 1'b0;
    end
    // frame every twice-decimation bit clock rises
    if (rise) begin
      if (s_reg.fcnt >= {s_reg.a_dec, 1'b0} - 8'h01) begin
        s_next.fcnt = 8'h00;
        s_next.frame = 1'b1;
      end else begin
        s_next.fcnt = s_reg.fcnt + 8'h01;
      end
    end
    // oscillator requests
    s_next.rc_req = s_reg.force_on | (s_reg.en && s_reg.csel == PCG_CSEL_SEC);
    s_next.x32 = (s_reg.csel == PCG_CSEL_XTAL);
  end

  // ****************************************
  // state register
  // ****************************************

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
      s_reg.cdiv <= PCG_CDIV_RST;
      s_reg.bdiv <= PCG_BDIV_RST;
      s_reg.dly <= PCG_DLY_RST;
      s_reg.dec <= PCG_DEC_RST;
      s_reg.a_bdiv <= PCG_BDIV_RST;
      s_reg.a_dly <= PCG_DLY_RST;
      s_reg.a_dec <= PCG_DEC_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************

  // zero-wait slave; unmapped reads return zero with an error
  always_comb begin
    prdata = 32'h00000000;
    unique case (paddr)
      PCG_CTRL_OFS: begin
        prdata[PCG_EN_POS] = s_reg.en;
        prdata[PCG_CHSET_POS +: 2] = s_reg.chset;
        prdata[PCG_SWAP_POS] = s_reg.swap;
        prdata[PCG_CSEL_POS +: 2] = s_reg.csel;
        prdata[PCG_FORCE_POS] = s_reg.force_on;
      end
      PCG_DIV_OFS: begin
        prdata[PCG_CDIV_POS +: 2] = s_reg.cdiv;
        prdata[PCG_BDIV_POS +: 4] = s_reg.bdiv;
        prdata[PCG_DLY_POS +: 3] = s_reg.dly;
        prdata[PCG_DEC_POS +: 7] = s_reg.dec;
      end
      PCG_STAT_OFS: begin
        prdata[PCG_ILL_POS] = dec_illegal;
        prdata[PCG_SEQ_POS] = s_reg.seq_err;
        prdata[PCG_LGATE_POS] = left_gate_enable;
        prdata[PCG_SGATE_POS] = stereo_gate_enable;
        prdata[PCG_RCREQ_POS] = s_reg.rc_req;
        prdata[PCG_X32_POS] = s_reg.x32;
      end
      default: prdata = 32'h00000000;
    endcase
  end

  assign pready = 1'b1;
  assign pslverr = psel & penable & !rd_ok;
  assign mic_bit_clock = s_reg.bclk;
  assign left_bit = s_reg.lbit;
  assign left_valid = s_reg.lval;
  assign right_bit = s_reg.rbit;
  assign right_valid = s_reg.rval;
  assign frame_strobe = s_reg.frame;
  assign decimation_setting = s_reg.a_dec;
  assign module_clock_select = s_reg.csel;
  assign force_secondary_rc_on = s_reg.force_on;
  assign secondary_rc_request = s_reg.rc_req;
  assign crystal32k_enable = s_reg.x32;

  // ****************************************
  // checks
  // ****************************************

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [8:0] rise_cnt; // top bit: decimation moved mid frame, so that length is not checked
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rise_cnt <= 9'h000;
    end else if (frame_strobe) begin
      rise_cnt <= 9'(rise);
    end else begin
      rise_cnt <= (rise_cnt + 9'(rise)) | {$changed(s_reg.a_dec), 8'h00};
    end
  end
  sequence s_rise_left;
    rise && !s_reg.a_swap;
  endsequence
  sequence s_left_out;
    left_valid && !right_valid;
  endsequence

  a_left_always: assert property (s_reg.a_en && core_tick |=> core_tick_left)
    else $error("left gate dropped while enabled");
  a_stereo_decode: assert property (stereo_gate_enable == (s_reg.a_en && s_reg.a_chset[1]))
    else $error("stereo gate does not match channel set");
  a_mono_quiet: assert property (!s_reg.a_chset[1] && $stable(s_reg.a_chset) |=> !right_valid && !right_bit)
    else $error("right output moved in mono");
  a_rise_left: assert property (s_rise_left |=> s_left_out)
    else $error("rising edge bit not routed left");
  a_swap_fall: assert property (fall && s_reg.a_swap |=> left_valid ##1 !left_valid)
    else $error("swapped falling edge bit not routed left");
  a_no_delay: assert property (s_reg.a_dly == 3'h0 && $stable(s_reg.a_dly) |-> ##1 mic_bit_clock == $past(bit_lvl))
    else $error("bit clock delayed with zero delay set");
  a_frame_len: assert property (frame_strobe && $stable(s_reg.a_dec) && !rise_cnt[8]
      && rise_cnt != 9'h000 |-> rise_cnt == {1'b0, s_reg.a_dec, 1'b0})
    else $error("frame length is not twice the decimation");
  a_xtal_side: assert property (s_reg.csel == PCG_CSEL_XTAL |=> crystal32k_enable)
    else $error("32k crystal not enabled with high speed crystal");
  a_force_hold: assert property (s_reg.force_on |=> secondary_rc_request [*2] or !s_reg.force_on)
    else $error("secondary oscillator request dropped while forced");
  a_seq_flag: assert property (wr && paddr == PCG_CTRL_OFS && !s_reg.force_on && pwdata[5:4] != s_reg.csel |=> s_reg.seq_err)
    else $error("unforced source change not flagged");
  a_sync_load: assert property (core_tick |=> s_reg.a_dec == $past(s_reg.dec))
    else $error("settings not carried over at converter edge");
endmodule

// ---- rtl/pcg_pkg.sv ----
// constants shared by the pdm clock generator files
package pcg_pkg;
  // register byte offsets
  localparam logic [11:0] PCG_CTRL_OFS = 12'h000;
  localparam logic [11:0] PCG_DIV_OFS = 12'h004;
  localparam logic [11:0] PCG_STAT_OFS = 12'h008;
  // control register fields
  localparam int PCG_EN_POS = 0;
  localparam int PCG_CHSET_POS = 1;
  localparam int PCG_SWAP_POS = 3;
  localparam int PCG_CSEL_POS = 4;
  localparam int PCG_FORCE_POS = 6;
  // divider register fields
  localparam int PCG_CDIV_POS = 0;
  localparam int PCG_BDIV_POS = 8;
  localparam int PCG_DLY_POS = 16;
  localparam int PCG_DEC_POS = 24;
  // status register fields
  localparam int PCG_ILL_POS = 0;
  localparam int PCG_SEQ_POS = 1;
  localparam int PCG_LGATE_POS = 2;
  localparam int PCG_SGATE_POS = 3;
  localparam int PCG_RCREQ_POS = 4;
  localparam int PCG_X32_POS = 5;
  // values after reset
  localparam logic [1:0] PCG_CDIV_RST = 2'h1;
  localparam logic [3:0] PCG_BDIV_RST = 4'h3;
  localparam logic [6:0] PCG_DEC_RST = 7'h10;
  localparam logic [2:0] PCG_DLY_RST = 3'h0;
  // legal decimation settings
  localparam logic [6:0] PCG_DEC_MIN = 7'h10;
  localparam logic [6:0] PCG_DEC_MAX = 7'h40;
  localparam logic [6:0] PCG_DEC_ALT = 7'h60;
  // module clock source codes
  localparam logic [1:0] PCG_CSEL_PRI = 2'h0;
  localparam logic [1:0] PCG_CSEL_SEC = 2'h1;
  localparam logic [1:0] PCG_CSEL_XTAL = 2'h2;
  // channel set codes, bit 1 high means stereo
  localparam logic [1:0] PCG_CHSET_MONO_L = 2'h0;
  localparam logic [1:0] PCG_CHSET_MONO_R = 2'h1;
  localparam int PCG_STEREO_BIT = 1;
endpackage

// ---- rtl/pcg_div.sv ----
// glitch-free divide-by-(n+1) clock generator, counted in steps
`timescale 1ns/100ps
module pcg_div #(
  parameter int W = 2
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic step,
  input wire logic [W-1:0] div_val,
  // generated clock
  output logic clk_lvl,
  output logic clk_tick
);
  import pcg_pkg::*;

  typedef struct packed {
    logic [W-1:0] cnt;
    logic [W-1:0] cur;
    logic lvl;
    logic tick;
  } pcg_div_t;

  pcg_div_t s_reg, s_next;

  // new ratio taken only at wrap, so no period is ever cut short
  always_comb begin
    s_next = s_reg;
    s_next.tick = 1'b0;
    if (step) begin
      if (s_reg.cnt == s_reg.cur) begin
        s_next.cnt = '0;
        s_next.cur = div_val;
        s_next.tick = 1'b1;
      end else begin
        s_next.cnt = s_reg.cnt + 1'b1;
      end
      s_next.lvl = (s_next.cnt <= (s_next.cur >> 1));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign clk_lvl = s_reg.lvl;
  assign clk_tick = s_reg.tick;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_div_wrap: assert property (step && s_reg.cnt == s_reg.cur |=> clk_tick && clk_lvl)
    else $error("divider did not wrap at its ratio");
  a_div_hold: assert property (!step |=> !clk_tick && $stable(clk_lvl))
    else $error("divided clock moved without a step");
endmodule

// ---- rtl/pcg_gate.sv ----
// clock gate that opens and closes only at whole periods
`timescale 1ns/100ps
module pcg_gate (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // source clock and enable
  input wire logic src_lvl,
  input wire logic src_tick,
  input wire logic en,
  // gated clock
  output logic g_lvl,
  output logic g_tick
);
  import pcg_pkg::*;

  typedef struct packed {
    logic en;
    logic lvl;
    logic tick;
  } pcg_gate_t;

  pcg_gate_t s_reg, s_next;
  logic en_eff;

  // enable sampled at period start only; costs one cycle of latency
  always_comb begin
    en_eff = src_tick ? en : s_reg.en;
    s_next.en = en_eff;
    s_next.lvl = src_lvl & en_eff;
    s_next.tick = src_tick & en;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign g_lvl = s_reg.lvl;
  assign g_tick = s_reg.tick;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_gate_whole: assert property (!src_tick && !s_reg.en |=> !g_lvl)
    else $error("gated clock opened mid period");
endmodule

// ---- dv/pcg_mic_model.sv ----
// model of a left and right pdm microphone pair sharing one data line
`timescale 1ns/100ps
module pcg_mic_model (
  // clock from the block
  input wire logic pclk,
  input wire logic mic_bit_clock,
  // value each microphone keeps sending
  input wire logic left_val,
  input wire logic right_val,
  // shared data line
  output logic mic_data
);
  logic last_clk = 1'b0;
  int idle = 0;
  // left talks after a falling edge, right after a rising edge
  // a stalled clock releases the line, so it wanders rather than hold
  always @(posedge pclk) begin
    if (mic_bit_clock !== last_clk) begin
      idle <= 0;
      mic_data <= mic_bit_clock ? right_val : left_val;
    end else if (idle > 12) begin
      mic_data <= ~mic_data;
    end else begin
      idle <= idle + 1;
    end
    last_clk <= mic_bit_clock;
  end
  initial mic_data = 1'b0;
endmodule

// ---- dv/pcg_clock_gen_tb.sv ----
// self-checking bench for the pdm clock generator
`timescale 1ns/100ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module pcg_clock_gen_tb;
  import pcg_pkg::*;
  // ****************
  // signals and rows
  // ****************
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, mic_data, mic_bit_clock;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, w;
  logic core_clk_left, core_clk_right, core_tick_left, core_tick_right, left_bit;
  logic left_valid, right_bit, right_valid, frame_strobe, force_secondary_rc_on;
  logic secondary_rc_request, crystal32k_enable, er, left_val, right_val;
  logic [6:0] decimation_setting;
  logic [1:0] module_clock_select;
  int err_count = 0;
  int cmp_count = 0;
  int p, lv, rv, rt, rh;
  typedef struct packed {logic [1:0] cd; logic [3:0] bd; logic [2:0] dl;
    logic [6:0] dc; logic ill;} pcg_drow_t;
  typedef struct packed {logic [1:0] ch; logic sw; logic lg; logic sg;
    logic lb; logic rb; logic rv;} pcg_crow_t;
  // divider inputs beside the illegal flag; periods follow from them
  pcg_drow_t dr [7] = '{{2'h1, 4'h3, 3'h0, 7'h10, 1'b0}, {2'h0, 4'h1, 3'h1, 7'h14, 1'b0},
    {2'h3, 4'h7, 3'h2, 7'h40, 1'b0}, {2'h2, 4'hF, 3'h3, 7'h60, 1'b0},
    {2'h1, 4'hB, 3'h7, 7'h20, 1'b0}, {2'h1, 4'h1, 3'h4, 7'h0F, 1'b1},
    {2'h1, 4'h1, 3'h5, 7'h41, 1'b1}};
  // channel set and swap beside gates, bits and right activity
  pcg_crow_t cr [4] = '{{2'h0, 1'b0, 5'b10100}, {2'h1, 1'b1, 5'b10000},
    {2'h2, 1'b0, 5'b11101}, {2'h3, 1'b1, 5'b11011}};

  pcg_clock_gen pcg_clock_gen_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .mic_data, .mic_bit_clock, .core_clk_left,
    .core_clk_right, .core_tick_left, .core_tick_right, .left_bit, .left_valid,
    .right_bit, .right_valid, .frame_strobe, .decimation_setting, .module_clock_select,
    .force_secondary_rc_on, .secondary_rc_request, .crystal32k_enable);
  pcg_mic_model pcg_mic_model_i (.pclk, .mic_bit_clock, .left_val, .right_val, .mic_data);

  // 100 MHz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // ****************
  // helpers
  // ****************
  function automatic logic [31:0] divw(input logic [1:0] cd, input logic [3:0] bd,
      input logic [2:0] dl, input logic [6:0] dc);
    return {1'b0, dc, 5'h00, dl, 4'h0, bd, 6'h00, cd};
  endfunction
  function automatic logic [31:0] ctrl(input logic en, input logic [1:0] ch,
      input logic sw, input logic [1:0] sel, input logic frc);
    return {25'h0000000, frc, sel, sw, ch, en};
  endfunction
  task results;
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task tmo;
    err_count++;
    $display("MISMATCH wait exp done got timeout");
    results();
  endtask
  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
      if (n > 50) tmo();
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h00000000);
    `CHK(nm, e, rd)
    `CHK("slverr", 1'b0, er)
  endtask
  task settle;
    repeat (2) @(posedge pclk);
    #1;
  endtask
  // cycles between two events: core tick, bit clock rise, frame strobe
  task automatic per(input int k, output int q);
    logic prev, hit;
    int n, c;
    n = 0;
    c = 0;
    q = 0;
    prev = mic_bit_clock;
    while (n < 2) begin
      @(posedge pclk);
      #1;
      case (k)
        0: hit = core_tick_left;
        1: hit = mic_bit_clock & ~prev;
        default: hit = frame_strobe;
      endcase
      prev = mic_bit_clock;
      if (n == 1) q++;
      if (hit === 1'b1) n++;
      c++;
      if (c > 30000) tmo();
    end
  endtask
  // reset mid-run or at start: outputs quiet, registers back to defaults
  task rst_chk;
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    #1;
    `CHK("pready", 1'b1, pready)
    `CHK("outs", {10'h000, PCG_DEC_RST, 5'h00}, {mic_bit_clock, core_clk_left, core_clk_right, core_tick_left,
      core_tick_right, left_bit, left_valid, right_bit, right_valid, frame_strobe,
      decimation_setting, module_clock_select, force_secondary_rc_on,
      secondary_rc_request, crystal32k_enable})
    @(posedge pclk);
    presetn <= 1'b1;
    rchk("ctrl", PCG_CTRL_OFS, 32'h00000000);
    rchk("div", PCG_DIV_OFS, divw(PCG_CDIV_RST, PCG_BDIV_RST, PCG_DLY_RST, PCG_DEC_RST));
    rchk("stat", PCG_STAT_OFS, 32'h00000000);
    $display("test reset done");
  endtask

  // ****************
  // main sequence
  // ****************
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    left_val = 1'b1;
    right_val = 1'b0;
    rst_chk();
    // divider rows, gates open in stereo
    apb(1'b1, PCG_CTRL_OFS, ctrl(1'b1, 2'h2, 1'b0, PCG_CSEL_PRI, 1'b0));
    for (int i = 0; i < 7; i++) begin
      w = divw(dr[i].cd, dr[i].bd, dr[i].dl, dr[i].dc);
      apb(1'b1, PCG_DIV_OFS, w);
      rchk("div", PCG_DIV_OFS, w);
      repeat (100) @(posedge pclk);
      per(0, p);
      `CHK("core period", int'(dr[i].cd) + 1, p)
      per(1, p);
      `CHK("bit period", (int'(dr[i].cd) + 1) * (int'(dr[i].bd) + 1), p)
      per(2, p);
      `CHK("frame", (int'(dr[i].cd) + 1) * (int'(dr[i].bd) + 1) * 2 * int'(dr[i].dc), p)
      `CHK("decimation", dr[i].dc, decimation_setting)
      apb(1'b0, PCG_STAT_OFS, 32'h00000000);
      `CHK("illegal", dr[i].ill, rd[PCG_ILL_POS])
    end
    $display("test dividers done");
    // channel rows; swap follows the mono side as software must
    apb(1'b1, PCG_DIV_OFS, divw(2'h1, 4'h7, 3'h0, 7'h10));
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, PCG_CTRL_OFS, ctrl(1'b1, cr[i].ch, cr[i].sw, PCG_CSEL_PRI, 1'b0));
      lv = 0;
      rv = 0;
      rt = 0;
      rh = 0;
      for (int j = 0; j < 160; j++) begin
        @(posedge pclk);
        #1;
        if (j > 40) begin
          lv += int'(left_valid === 1'b1);
          rv += int'(right_valid === 1'b1);
          rt += int'(core_tick_right === 1'b1);
          rh += int'(right_bit === 1'b1);
        end
      end
      apb(1'b0, PCG_STAT_OFS, 32'h00000000);
      `CHK("left gate", cr[i].lg, rd[PCG_LGATE_POS])
      `CHK("stereo gate", cr[i].sg, rd[PCG_SGATE_POS])
      `CHK("left valid", 1'b1, lv > 0)
      `CHK("right tick", cr[i].sg, rt > 0)
      `CHK("right valid", cr[i].rv, rv > 0)
      `CHK("right high", cr[i].rb, rh > 0)
      `CHK("left bit", cr[i].lb, left_bit)
      `CHK("right bit", cr[i].rb, right_bit)
    end
    $display("test channels done");
    // source change to the secondary oscillator and clean shutdown
    apb(1'b1, PCG_CTRL_OFS, ctrl(1'b0, 2'h0, 1'b0, PCG_CSEL_PRI, 1'b1));
    settle();
    `CHK("rc request", 1'b1, secondary_rc_request)
    apb(1'b1, PCG_CTRL_OFS, ctrl(1'b0, 2'h0, 1'b0, PCG_CSEL_SEC, 1'b1));
    apb(1'b1, PCG_CTRL_OFS, ctrl(1'b1, 2'h0, 1'b0, PCG_CSEL_SEC, 1'b1));
    settle();
    `CHK("select", PCG_CSEL_SEC, module_clock_select)
    `CHK("force", 1'b1, force_secondary_rc_on)
    apb(1'b1, PCG_CTRL_OFS, ctrl(1'b1, 2'h0, 1'b0, PCG_CSEL_PRI, 1'b1));
    apb(1'b1, PCG_CTRL_OFS, ctrl(1'b0, 2'h0, 1'b0, PCG_CSEL_PRI, 1'b0));
    settle();
    `CHK("rc request", 1'b0, secondary_rc_request)
    // crystal source, force dropped since secondary is not chosen
    apb(1'b1, PCG_CTRL_OFS, ctrl(1'b0, 2'h0, 1'b0, PCG_CSEL_PRI, 1'b1));
    apb(1'b1, PCG_CTRL_OFS, ctrl(1'b0, 2'h0, 1'b0, PCG_CSEL_XTAL, 1'b1));
    apb(1'b1, PCG_CTRL_OFS, ctrl(1'b1, 2'h0, 1'b0, PCG_CSEL_XTAL, 1'b0));
    settle();
    `CHK("crystal32k", 1'b1, crystal32k_enable)
    `CHK("rc request", 1'b0, secondary_rc_request)
    rchk("stat", PCG_STAT_OFS, 32'h00000024);
    // deliberate change without force, then clear the sticky flag
    apb(1'b1, PCG_CTRL_OFS, ctrl(1'b0, 2'h0, 1'b0, PCG_CSEL_PRI, 1'b0));
    settle();
    `CHK("crystal32k", 1'b0, crystal32k_enable)
    rchk("seq err", PCG_STAT_OFS, 32'h00000002);
    apb(1'b1, PCG_STAT_OFS, 32'h00000002);
    rchk("seq clr", PCG_STAT_OFS, 32'h00000000);
    $display("test source done");
    // unmapped place: refused, nothing written
    apb(1'b0, 12'h00C, 32'h00000000);
    `CHK("unmapped rd", 32'h00000000, rd)
    `CHK("unmapped err", 1'b1, er)
    apb(1'b1, 12'h00C, 32'hFFFFFFFF);
    rchk("ctrl", PCG_CTRL_OFS, 32'h00000000);
    $display("test unmapped done");
    apb(1'b1, PCG_CTRL_OFS, ctrl(1'b1, 2'h2, 1'b0, PCG_CSEL_PRI, 1'b0));
    repeat (50) @(posedge pclk);
    rst_chk();
    results();
  end
endmodule
